// [hdl/ijcsr_top.sv]
// Jumperless setting register, base select stepping and soft reset group
// Behaviour
// - Jumperless setting reads back as a read-only byte, zero after reset.
// - Bits 7:6 report interrupt channel, 00 to 11 for the four channels.
// - Bits 2:0 select the I/O base window per the fixed decode table.
// - Eight reset locations are decoded and acted on only in ISA mode.
// - Any write to a reset location reinitialises the four LAN sub-blocks.
// - That write also resets internal registers except base and jumperless ones.
// - Each read of the base address register steps base select by one, unless an initialisation load in the same cycle wins.
module ijcsr_top #(
    parameter int           RST_CYCLES = ijcsr_pkg::SOFT_RST_CYCLES,
    parameter logic [9:0]   BASE_WIN_4 = ijcsr_pkg::BASE_WIN_100_DFLT
) (
    // Clock, reset and clock enable
    input  wire logic       CLK,
    input  wire logic       RST_B,
    input  wire logic       CE,
    // Mode straps
    input  wire logic       ISA_MODE,
    input  wire logic       JUMPERLESS_MODE,
    // Result of the jumperless initialisation
    input  wire logic       INIT_LOAD,
    input  wire logic [1:0] INIT_IRQ,
    input  wire logic [2:0] INIT_BASE,
    // Host register port
    input  wire logic [4:0] ADDR,
    input  wire logic       RD,
    input  wire logic       WR,
    input  wire logic [7:0] WDATA,
    output logic      [7:0] RDATA,
    // Configuration seen by the rest of the chip
    output logic      [1:0] IRQ_SELECT,
    output logic      [2:0] BASE_SELECT,
    output logic      [9:0] BASE_START,
    // Soft reset to sub-blocks and internal registers
    output logic            BM_RST,
    output logic            DLC_RST,
    output logic            CODEC_RST,
    output logic            XCVR_RST,
    output logic            REG_RST
);
    logic [1:0] irq_q;
    logic [2:0] base_q;
    logic [7:0] rdata_q;
    logic       res_hit;
    logic       base_rd;
    logic       soft_rst;

    // Reset group spans eight consecutive addresses
    function automatic logic is_reset_loc(input logic [4:0] a);
        return (a >= ijcsr_pkg::SOFT_RESET_FIRST) && (a <= ijcsr_pkg::SOFT_RESET_LAST);
    endfunction : is_reset_loc

    // Window start for a base select code
    function automatic logic [9:0] base_decode(input logic [2:0] s);
        case (s)
            3'h0:    return ijcsr_pkg::BASE_WIN_000;
            3'h1:    return ijcsr_pkg::BASE_WIN_001;
            3'h2:    return ijcsr_pkg::BASE_WIN_010;
            3'h3:    return ijcsr_pkg::BASE_WIN_011;
            3'h4:    return BASE_WIN_4;
            3'h5:    return ijcsr_pkg::BASE_WIN_101;
            3'h6:    return ijcsr_pkg::BASE_WIN_110;
            default: return ijcsr_pkg::BASE_WIN_111;
        endcase
    endfunction : base_decode

    // Qualified strobes; reset locations are dead outside ISA mode
    assign res_hit = CE && WR && ISA_MODE && is_reset_loc(ADDR);
    assign base_rd = CE && RD && (ADDR == ijcsr_pkg::IO_BASE_ADDR_OFS);

    // Interrupt channel: loaded only by initialisation, never by host write
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_q <= ijcsr_pkg::IRQ_SELECT_RST;
        end else if (CE && INIT_LOAD) begin
            irq_q <= INIT_IRQ;
        end
    end

    // Base select: soft reset deliberately leaves it alone
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            base_q <= ijcsr_pkg::BASE_SELECT_RST;
        end else if (CE && INIT_LOAD) begin
            base_q <= INIT_BASE;
        end else if (base_rd) begin
            base_q <= base_q + 3'h1;
        end
    end

    // Read data registered; internal read path is cleared by soft reset
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= ijcsr_pkg::RDATA_RST;
        end else if (CE) begin
            if (soft_rst) begin
                rdata_q <= ijcsr_pkg::RDATA_RST;
            end else if (RD && ADDR == ijcsr_pkg::JUMPERLESS_OFS) begin
                rdata_q <= {irq_q, 3'h0, base_q};
            end else if (RD) begin
                rdata_q <= ijcsr_pkg::RDATA_RST;   // Base register reads mean nothing
            end
        end
    end

    // One stretcher feeds every sub-block so they leave reset together
    ijcsr_rst_pulse #(
        .CYCLES (RST_CYCLES)
    ) u_rst (
        .clk    (CLK),
        .rst_b  (RST_B),
        .ce     (CE),
        .trig   (res_hit),
        .pulse  (soft_rst)
    );

    // Outputs
    assign RDATA       = rdata_q;
    assign IRQ_SELECT  = irq_q;
    assign BASE_SELECT = base_q;
    assign BASE_START  = base_decode(base_q);
    assign BM_RST      = soft_rst;
    assign DLC_RST     = soft_rst;
    assign CODEC_RST   = soft_rst;
    assign XCVR_RST    = soft_rst;
    assign REG_RST     = soft_rst;

    // Assertions
    jl_reset_zero_a: assert property (@(posedge CLK)
        $rose(RST_B) |-> (irq_q == 2'h0 && base_q == 3'h0))
        else $error("jumperless fields not zero after reset");

    irq_field_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && RD && ADDR == ijcsr_pkg::JUMPERLESS_OFS && !soft_rst)
        |=> RDATA[7:6] == $past(irq_q))
        else $error("irq field wrong on read");

    base_decode_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (base_q == 3'h3 |-> BASE_START == 10'h240)
        and (base_q == 3'h6 |-> BASE_START == 10'h380))
        else $error("base window decode wrong");

    no_rst_nonisa_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && WR && !ISA_MODE && !soft_rst) |=> !soft_rst)
        else $error("soft reset outside ISA mode");

    // Pulse lasts four enabled cycles and then drops, unless a later reset write
    // or a cycle with clock enable low has stretched it
    soft_rst_len_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (res_hit && !soft_rst && RST_CYCLES == 4) |=> soft_rst [*4] ##1
        (!soft_rst || $past(res_hit) || $past(res_hit, 2) || $past(res_hit, 3)
         || $past(res_hit, 4) || !$past(CE) || !$past(CE, 2) || !$past(CE, 3) || !$past(CE, 4)))
        else $error("soft reset pulse length wrong");

    keep_base_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (res_hit && !INIT_LOAD && !base_rd) |=> base_q == $past(base_q))
        else $error("base select lost on soft reset");

    base_step_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (base_rd && !INIT_LOAD) |=> base_q == $past(base_q) + 3'h1)
        else $error("base select did not advance");

    jl_write_ign_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (!INIT_LOAD && !base_rd) |=> $stable(irq_q) && $stable(base_q))
        else $error("jumperless changed without cause");

    unused_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
        RDATA[5:3] == 3'h0)
        else $error("unused bits not zero");

    // Fresh interrupt and base codes land in the register one cycle after the load
    init_load_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && INIT_LOAD) |=> (irq_q == $past(INIT_IRQ) && base_q == $past(INIT_BASE)))
        else $error("initialisation result not captured");

    // Base select field of a jumperless read carries the code seen at the read
    base_field_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && RD && ADDR == ijcsr_pkg::JUMPERLESS_OFS && !soft_rst)
        |=> RDATA[2:0] == $past(base_q))
        else $error("base field wrong on read");

    // Remaining window codes except 100, held against the fixed table rather than the package
    base_window_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (base_q != 3'h0 || BASE_START == 10'h260)
        && (base_q != 3'h1 || BASE_START == 10'h280)
        && (base_q != 3'h2 || BASE_START == 10'h2A0)
        && (base_q != 3'h5 || BASE_START == 10'h320)
        && (base_q != 3'h7 || BASE_START == 10'h300))
        else $error("base window table wrong");

    // Reset writes are taken on the edge and the pulse starts at once
    rst_start_a: assert property (@(posedge CLK) disable iff (!RST_B)
        res_hit |=> soft_rst)
        else $error("soft reset did not start");

    // The interrupt channel survives a reset write just as the base select does
    keep_irq_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (res_hit && !INIT_LOAD) |=> irq_q == $past(irq_q))
        else $error("irq channel lost on soft reset");

    // Read path is one of the internal registers that a reset write clears
    rdata_clear_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && soft_rst) |=> RDATA == 8'h00)
        else $error("read data not cleared by soft reset");

    // Reads of the base register and of unmapped locations return zero
    read_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (CE && RD && ADDR != ijcsr_pkg::JUMPERLESS_OFS && !soft_rst) |=> RDATA == 8'h00)
        else $error("meaningless read not zero");

    // Read data stands between reads so a slow host still sees its byte
    rdata_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !(CE && (RD || soft_rst)) |=> $stable(RDATA))
        else $error("read data changed without a read");

    // Clock enable low freezes every register, the pulse stretcher included
    ce_freeze_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !CE |=> ($stable(base_q) && $stable(irq_q) && $stable(soft_rst) && $stable(RDATA)))
        else $error("state moved with clock enable low");
endmodule : ijcsr_top

// [hdl/ijcsr_pkg.sv]
// Constants shared by the jumperless configuration and soft reset block
package ijcsr_pkg;
    // Register locations on the five-bit system address
    localparam logic [4:0] IO_BASE_ADDR_OFS   = 5'h12;
    localparam logic [4:0] JUMPERLESS_OFS     = 5'h13;
    localparam logic [4:0] SOFT_RESET_FIRST   = 5'h18;
    localparam logic [4:0] SOFT_RESET_LAST    = 5'h1F;
    // Jumperless setting field positions
    localparam int         IRQ_SELECT_LO_POS  = 6;
    localparam int         IRQ_SELECT_HI_POS  = 7;
    localparam int         BASE_SELECT_LO_POS = 0;
    localparam int         BASE_SELECT_HI_POS = 2;
    // Reset values
    localparam logic [7:0] JUMPERLESS_RST     = 8'h00;
    localparam logic [1:0] IRQ_SELECT_RST     = 2'h0;
    localparam logic [2:0] BASE_SELECT_RST    = 3'h0;
    localparam logic [7:0] RDATA_RST          = 8'h00;
    // Start of each 32-byte I/O window per base select code
    localparam logic [9:0] BASE_WIN_000       = 10'h260;
    localparam logic [9:0] BASE_WIN_001       = 10'h280;
    localparam logic [9:0] BASE_WIN_010       = 10'h2A0;
    localparam logic [9:0] BASE_WIN_011       = 10'h240;
    localparam logic [9:0] BASE_WIN_100_DFLT  = 10'h200;
    localparam logic [9:0] BASE_WIN_101       = 10'h320;
    localparam logic [9:0] BASE_WIN_110       = 10'h380;
    localparam logic [9:0] BASE_WIN_111       = 10'h300;
    // Length of the soft reset pulse to the sub-blocks
    localparam int         SOFT_RST_CYCLES    = 4;
    // Soft reset sequencer states
    typedef enum logic [0:0] {
        IJCSR_IDLE = 1'b0,
        IJCSR_BUSY = 1'b1
    } ijcsr_rst_state_t;
endpackage : ijcsr_pkg

// [hdl/ijcsr_rst_pulse.sv]
// Soft reset pulse stretcher: holds its output for a fixed number of cycles
module ijcsr_rst_pulse #(
    parameter int CYCLES = ijcsr_pkg::SOFT_RST_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // Trigger and stretched pulse
    input  wire logic trig,
    output logic      pulse
);
    localparam int CW = (CYCLES < 2) ? 1 : $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    ijcsr_pkg::ijcsr_rst_state_t state_q;
    logic [CW-1:0]               cnt_q;

    // A new trigger while busy restarts the count so every write is honoured
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ijcsr_pkg::IJCSR_IDLE;
            cnt_q   <= '0;
        end else if (ce) begin
            case (state_q)
                ijcsr_pkg::IJCSR_IDLE: begin
                    if (trig) begin
                        state_q <= ijcsr_pkg::IJCSR_BUSY;
                        cnt_q   <= LOAD;
                    end
                end
                ijcsr_pkg::IJCSR_BUSY: begin
                    if (trig) begin
                        cnt_q <= LOAD;
                    end else if (cnt_q == CW'(1)) begin
                        state_q <= ijcsr_pkg::IJCSR_IDLE;
                        cnt_q   <= '0;
                    end else begin
                        cnt_q <= cnt_q - CW'(1);
                    end
                end
                default: begin
                    state_q <= ijcsr_pkg::IJCSR_IDLE;
                    cnt_q   <= '0;
                end
            endcase
        end
    end

    // Output straight from state so it is glitch free
    assign pulse = (state_q == ijcsr_pkg::IJCSR_BUSY);
endmodule : ijcsr_rst_pulse

// [dv/ijcsr_host_model.sv]
// Host processor model: single byte reads and writes on the register port
module ijcsr_host_model (
    // Clock and returned data
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    // Strobes, address and write data
    output logic      [4:0] addr,
    output logic            rd,
    output logic            wr,
    output logic      [7:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        addr = 5'h00;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 8'h00;
    end

    // One-cycle strobe; released lines show the inverse so stale values never match
    task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(negedge clk);
        addr = a;
        wdata = d;
        rd = !w;
        wr = w;
        @(negedge clk);
        q = rdata;
        rd = 1'b0;
        wr = 1'b0;
        addr = ~a;
        wdata = ~d;
    endtask : access
endmodule : ijcsr_host_model

// [dv/testbench.sv]
// Self-checking bench for the jumperless configuration and soft reset block
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst_b, ce, isa_mode, init_load, rd, wr;
    logic [1:0] init_irq, irq_select, irq;
    logic [2:0] init_base, base_select, bs;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, q;
    logic [9:0] base_start;
    logic       bm_rst, dlc_rst, codec_rst, xcvr_rst, reg_rst;
    int         n_fail = 0;
    int         n_compared = 0;

    // Design under test; the jumperless strap is held on
    ijcsr_top ijcsr_top_inst (.CLK(clk), .RST_B(rst_b), .CE(ce), .ISA_MODE(isa_mode),
        .JUMPERLESS_MODE(1'b1), .INIT_LOAD(init_load), .INIT_IRQ(init_irq),
        .INIT_BASE(init_base), .ADDR(addr), .RD(rd), .WR(wr), .WDATA(wdata),
        .RDATA(rdata), .IRQ_SELECT(irq_select), .BASE_SELECT(base_select),
        .BASE_START(base_start), .BM_RST(bm_rst), .DLC_RST(dlc_rst),
        .CODEC_RST(codec_rst), .XCVR_RST(xcvr_rst), .REG_RST(reg_rst));
    ijcsr_host_model ijcsr_host_model_inst (.clk(clk), .rdata(rdata), .addr(addr),
        .rd(rd), .wr(wr), .wdata(wdata));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Expected window start; code 100 is unknown, so the design default is used
    function automatic logic [9:0] base_win(input logic [2:0] s);
        case (s)
            3'h0: return 10'h260;
            3'h1: return 10'h280;
            3'h2: return 10'h2A0;
            3'h3: return 10'h240;
            3'h4: return ijcsr_pkg::BASE_WIN_100_DFLT;
            3'h5: return 10'h320;
            3'h6: return 10'h380;
            default: return 10'h300;
        endcase
    endfunction : base_win

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        ijcsr_host_model_inst.access(1'b0, a, 8'h00, q);
        `CHK(q, exp)
    endtask : rd_chk

    // Write one reset location, then count cycles with the reset outputs high
    task automatic soft_rst(input logic [4:0] a, input logic isa, input int exp_n);
        int n;
        n = 0;
        isa_mode = isa;
        ijcsr_host_model_inst.access(1'b1, a, 8'($urandom), q);
        for (int i = 0; i < 6; i++) begin
            n += int'(bm_rst === 1'b1);
            `CHK({dlc_rst, codec_rst, xcvr_rst, reg_rst}, {4{bm_rst}})
            @(negedge clk);
        end
        `CHK(n, exp_n)
        isa_mode = 1'b1;
    endtask : soft_rst

    task automatic test_done();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    // Watchdog against a hang
    initial begin
        #200us;
        n_fail++;
        test_done();
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        isa_mode = 1'b1;
        init_load = 1'b0;
        init_irq = 2'h0;
        init_base = 3'h0;
        void'($urandom(4));
        for (int r = 0; r < 2; r++) begin
            repeat (4) @(negedge clk);
            rst_b = 1'b1;
            `CHK({rdata, irq_select, base_select}, 13'h0000)
            `CHK(base_start, 10'h260)
            rd_chk(ijcsr_pkg::JUMPERLESS_OFS, 8'h00);
            // Every interrupt code with a random base; writes must not stick
            for (int i = 0; i < 4; i++) begin
                irq = 2'(i);
                bs = 3'($urandom);
                init_irq = irq;
                init_base = bs;
                init_load = 1'b1;
                @(negedge clk);
                init_load = 1'b0;
                rd_chk(ijcsr_pkg::JUMPERLESS_OFS, {irq, 3'h0, bs});
                ijcsr_host_model_inst.access(1'b1, ijcsr_pkg::JUMPERLESS_OFS, ~q, q);
                rd_chk(ijcsr_pkg::JUMPERLESS_OFS, {irq, 3'h0, bs});
            end
            // Nine base reads, one idle cycle apart, wrap through all codes
            for (int i = 0; i < 9; i++) begin
                rd_chk(ijcsr_pkg::IO_BASE_ADDR_OFS, 8'h00);
                bs = bs + 3'h1;
                `CHK(base_select, bs)
                `CHK(base_start, base_win(bs))
            end
            rd_chk(ijcsr_pkg::JUMPERLESS_OFS, {irq, 3'h0, bs});
            // Clock enable low: a base read and a reset write are both ignored
            ce = 1'b0;
            rd_chk(ijcsr_pkg::IO_BASE_ADDR_OFS, {irq, 3'h0, bs});
            `CHK(base_select, bs)
            soft_rst(ijcsr_pkg::SOFT_RESET_LAST, 1'b1, 0);
            ce = 1'b1;
            // Each reset location; read data clears, settings are kept
            for (int i = 0; i < 8; i++) begin
                soft_rst(5'(ijcsr_pkg::SOFT_RESET_FIRST + i), 1'b1, 4);
                `CHK(rdata, 8'h00)
                `CHK({irq_select, base_select}, {irq, bs})
                rd_chk(ijcsr_pkg::JUMPERLESS_OFS, {irq, 3'h0, bs});
            end
            soft_rst(5'(ijcsr_pkg::SOFT_RESET_FIRST + 3'($urandom)), 1'b0, 0);
            rd_chk(5'h05, 8'h00);
            @(negedge clk);
            rst_b = 1'b0;
        end
        test_done();
    end
endmodule : testbench
